/* src/fwsr_device.sv */
// flash device end: embedded program/erase with write status reporting
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module fwsr_device #(
  parameter int WINDOW_CYCLES = fwsr_pkg::WINDOW_CYCLES,
  parameter int PROG_CYCLES   = fwsr_pkg::PROG_CYCLES,
  parameter int ERASE_CYCLES  = fwsr_pkg::ERASE_CYCLES,
  parameter int PULSE_LIMIT   = fwsr_pkg::PULSE_LIMIT
) (
  input  wire logic aclk,    // clock
  input  wire logic aresetn, // sync reset, active low
  fwsr_if.device    link,    // host link
  output logic      busy,    // embedded operation under way
  output logic      failed   // time-limit failure pending reset
);
  localparam int AW = fwsr_pkg::AW;
  localparam int DW = fwsr_pkg::DW;
  localparam int NS = fwsr_pkg::SECTORS;

  typedef enum logic [2:0] {
    D_READY     = 3'b000,
    D_PROG      = 3'b001,
    D_WINDOW    = 3'b010,
    D_ERASE     = 3'b011,
    D_SUSP      = 3'b100,
    D_SUSP_PROG = 3'b101,
    D_FAIL      = 3'b110
  } fwsr_dstate_type;

  fwsr_dstate_type state;
  logic [DW-1:0]   mem [2**AW];
  logic [AW-1:0]   prog_addr;
  logic [DW-1:0]   prog_data;
  logic            prog_bad;
  logic            fail_in_susp;
  logic [NS-1:0]   erase_mask;
  logic [31:0]     prog_timer;
  logic [31:0]     erase_timer;
  logic            toggle;
  logic            sector_toggle;
  logic            hit;
  logic            sect_hit;
  logic [DW-1:0]   status;
  logic            is_read;
  logic            is_cmd;
  logic            prog_done;
  logic            prog_fail;
  logic            erase_done;

  function automatic logic [2:0] sector_of(input logic [AW-1:0] a);
    return a[AW-1:AW-3];
  endfunction

  function automatic logic [1:0] bank_of(input logic [AW-1:0] a);
    return a[AW-1:AW-2];
  endfunction

  assign is_read = link.req && link.cmd == fwsr_pkg::CMD_READ;
  assign is_cmd = link.req && link.cmd != fwsr_pkg::CMD_READ;
  assign prog_done = !prog_bad && prog_timer == PROG_CYCLES - 1;
  assign prog_fail = prog_bad && prog_timer == PULSE_LIMIT - 1;
  assign erase_done = erase_timer == ERASE_CYCLES - 1;

  // which reads get status instead of array data
  always_comb begin
    sect_hit = erase_mask[sector_of(link.addr)];
    unique case (state)
      D_PROG, D_SUSP_PROG, D_FAIL: hit = bank_of(link.addr) == bank_of(prog_addr);
      D_WINDOW, D_ERASE: hit = erase_mask[{bank_of(link.addr), 1'b0}]
                             || erase_mask[{bank_of(link.addr), 1'b1}];
      D_SUSP: hit = sect_hit;
      default: hit = 1'b0;
    endcase
  end

  // status word for the current operation
  always_comb begin
    status = '0;
    status[fwsr_pkg::TOGGLE_BIT] = toggle;
    unique case (state)
      D_PROG, D_SUSP_PROG: status[fwsr_pkg::POLL_BIT] = ~prog_data[fwsr_pkg::POLL_BIT];
      D_FAIL: begin
        status[fwsr_pkg::POLL_BIT] = ~prog_data[fwsr_pkg::POLL_BIT];
        status[fwsr_pkg::LIMIT_BIT] = 1'b1;
      end
      D_WINDOW: status[fwsr_pkg::SECTOR_TOGGLE_BIT] = sect_hit && sector_toggle;
      D_ERASE: begin
        status[fwsr_pkg::WINDOW_BIT] = 1'b1;
        status[fwsr_pkg::SECTOR_TOGGLE_BIT] = sect_hit && sector_toggle;
      end
      D_SUSP: begin
        status[fwsr_pkg::POLL_BIT] = 1'b1;
        status[fwsr_pkg::SECTOR_TOGGLE_BIT] = sector_toggle;
      end
      default: status = '0;
    endcase
  end

  // operation sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= D_READY;
      prog_addr <= '0;
      prog_data <= '0;
      prog_bad <= 1'b0;
      fail_in_susp <= 1'b0;
      erase_mask <= '0;
    end else begin
      unique case (state)
        D_READY: begin
          if (is_cmd && link.cmd == fwsr_pkg::CMD_PROG) begin
            prog_addr <= link.addr;
            prog_data <= link.wdata;
            prog_bad <= |(link.wdata & ~mem[link.addr]);
            state <= D_PROG;
          end else if (is_cmd && link.cmd == fwsr_pkg::CMD_SECT_ERASE) begin
            erase_mask <= NS'(1) << sector_of(link.addr);
            state <= D_WINDOW;
          end else if (is_cmd && link.cmd == fwsr_pkg::CMD_CHIP_ERASE) begin
            erase_mask <= '1;
            state <= D_ERASE;
          end
        end
        D_PROG: begin
          if (prog_fail) begin
            fail_in_susp <= 1'b0;
            state <= D_FAIL;
          end else if (prog_done) begin
            state <= D_READY;
          end
        end
        D_WINDOW: begin
          if (is_cmd && link.cmd == fwsr_pkg::CMD_SECT_ERASE) begin
            erase_mask <= erase_mask | (NS'(1) << sector_of(link.addr));
          end else if (erase_timer == WINDOW_CYCLES - 1) begin
            state <= D_ERASE;
          end
        end
        D_ERASE: begin
          if (is_cmd && link.cmd == fwsr_pkg::CMD_SUSPEND) begin
            state <= D_SUSP;
          end else if (erase_done) begin
            erase_mask <= '0;
            state <= D_READY;
          end
        end
        D_SUSP: begin
          if (is_cmd && link.cmd == fwsr_pkg::CMD_RESUME) begin
            state <= D_ERASE;
          end else if (is_cmd && link.cmd == fwsr_pkg::CMD_PROG) begin
            prog_addr <= link.addr;
            prog_data <= link.wdata;
            prog_bad <= |(link.wdata & ~mem[link.addr]);
            state <= D_SUSP_PROG;
          end
        end
        D_SUSP_PROG: begin
          if (prog_fail) begin
            fail_in_susp <= 1'b1;
            state <= D_FAIL;
          end else if (prog_done) begin
            state <= D_SUSP;
          end
        end
        D_FAIL: begin
          if (is_cmd && link.cmd == fwsr_pkg::CMD_RESET) begin
            state <= fail_in_susp ? D_SUSP : D_READY;
          end
        end
        default: state <= D_READY;
      endcase
    end
  end

  // program pulse counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prog_timer <= '0;
    end else if (state == D_PROG || state == D_SUSP_PROG) begin
      prog_timer <= prog_timer + 32'h1;
    end else begin
      prog_timer <= '0;
    end
  end

  // acceptance window, then erase duration; held while suspended
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      erase_timer <= '0;
    end else if (state == D_WINDOW) begin
      if ((is_cmd && link.cmd == fwsr_pkg::CMD_SECT_ERASE) || erase_timer == WINDOW_CYCLES - 1) begin
        erase_timer <= '0;
      end else begin
        erase_timer <= erase_timer + 32'h1;
      end
    end else if (state == D_ERASE) begin
      erase_timer <= erase_timer + 32'h1;
    end else if (state == D_READY) begin
      erase_timer <= '0;
    end
  end

  // array contents
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem[i] <= fwsr_pkg::ERASED;
      end
    end else if ((state == D_PROG || state == D_SUSP_PROG) && prog_done) begin
      mem[prog_addr] <= mem[prog_addr] & prog_data;
    end else if (state == D_ERASE && erase_done && !(is_cmd && link.cmd == fwsr_pkg::CMD_SUSPEND)) begin
      for (int i = 0; i < 2**AW; i++) begin
        if (erase_mask[sector_of(AW'(i))]) begin
          mem[i] <= fwsr_pkg::ERASED;
        end
      end
    end
  end

  // toggle bit flips on each status read except in D_SUSP; sector toggle only on status reads of erasing sectors
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      toggle <= 1'b0;
      sector_toggle <= 1'b0;
    end else if (is_read && hit) begin
      if (state != D_SUSP) begin
        toggle <= ~toggle;
      end
      if (sect_hit && (state == D_WINDOW || state == D_ERASE || state == D_SUSP)) begin
        sector_toggle <= ~sector_toggle;
      end
    end
  end

  // read answer, same path in every mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.rvalid <= 1'b0;
      link.rdata <= '0;
    end else begin
      link.rvalid <= is_read;
      if (is_read) begin
        link.rdata <= hit ? status : mem[link.addr];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      failed <= 1'b0;
    end else begin
      busy <= state != D_READY;
      failed <= state == D_FAIL;
    end
  end
endmodule
`default_nettype wire

/* src/fwsr_pkg.sv */
// constants shared by the flash status device and its host controller
package fwsr_pkg;
  localparam int AW = 6;
  localparam int DW = 16;
  localparam int SECTORS = 8;
  localparam logic [DW-1:0] ERASED = 16'hFFFF;
  // status bit positions
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int LIMIT_BIT = 5;
  localparam int WINDOW_BIT = 3;
  localparam int SECTOR_TOGGLE_BIT = 2;
  // link commands
  localparam logic [2:0] CMD_READ = 3'h0;
  localparam logic [2:0] CMD_PROG = 3'h1;
  localparam logic [2:0] CMD_SECT_ERASE = 3'h2;
  localparam logic [2:0] CMD_CHIP_ERASE = 3'h3;
  localparam logic [2:0] CMD_SUSPEND = 3'h4;
  localparam logic [2:0] CMD_RESUME = 3'h5;
  localparam logic [2:0] CMD_RESET = 3'h6;
  // timing
  localparam int CLK_MHZ = 100;
  localparam int WINDOW_US = 50;
  localparam int WINDOW_CYCLES = WINDOW_US * CLK_MHZ;
  localparam int PROG_CYCLES = 16;
  localparam int ERASE_CYCLES = 64;
  localparam int PULSE_LIMIT = 32;
  // host register map
  localparam logic [3:0] REG_ADDR = 4'h0;
  localparam logic [3:0] REG_DATA = 4'h4;
  localparam logic [3:0] REG_CTRL = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hC;
  localparam int STAT_BUSY = 0;
  localparam int STAT_OK = 1;
  localparam int STAT_FAIL = 2;
  localparam int STAT_RDATA = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* src/fwsr_if.sv */
// link between host controller and flash device
`timescale 1ns/1ps
`default_nettype none
interface fwsr_if;
  logic                       req;
  logic [2:0]                 cmd;
  logic [fwsr_pkg::AW-1:0]    addr;
  logic [fwsr_pkg::DW-1:0]    wdata;
  logic                       rvalid;
  logic [fwsr_pkg::DW-1:0]    rdata;
  modport host(output req, cmd, addr, wdata, input rvalid, rdata);
  modport device(input req, cmd, addr, wdata, output rvalid, rdata);
endinterface
`default_nettype wire

/* src/fwsr_host.sv */
// host controller end: AXI4-Lite registers, command issue and status polling
`timescale 1ns/1ps
`default_nettype none
module fwsr_host (
  input  wire logic        aclk,    // clock
  input  wire logic        aresetn, // sync reset, active low
  input  wire logic        awvalid, // write address valid
  output logic             awready, // write address ready
  input  wire logic [3:0]  awaddr,  // write address
  input  wire logic        wvalid,  // write data valid
  output logic             wready,  // write data ready
  input  wire logic [31:0] wdata,   // write data
  input  wire logic [3:0]  wstrb,   // byte strobes
  output logic             bvalid,  // write response valid
  input  wire logic        bready,  // write response ready
  output logic [1:0]       bresp,   // write response
  input  wire logic        arvalid, // read address valid
  output logic             arready, // read address ready
  input  wire logic [3:0]  araddr,  // read address
  output logic             rvalid,  // read data valid
  input  wire logic        rready,  // read data ready
  output logic [31:0]      rdata,   // read data
  output logic [1:0]       rresp,   // read response
  fwsr_if.host             link     // flash link
);
  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_SEND  = 3'b001,
    H_WAIT  = 3'b010,
    H_POLL  = 3'b011,
    H_PWAIT = 3'b100,
    H_RESET = 3'b101
  } fwsr_hstate_type;

  fwsr_hstate_type             hstate;
  logic [3:0]                  aw_q;
  logic [31:0]                 w_q;
  logic [3:0]                  ws_q;
  logic [fwsr_pkg::AW-1:0]     op_addr;
  logic [fwsr_pkg::DW-1:0]     op_data;
  logic [2:0]                  op;
  logic                        st_ok;
  logic                        st_fail;
  logic [fwsr_pkg::DW-1:0]     rd_q;
  logic                        first;
  logic                        tog_first;
  logic                        rechk;
  logic                        wr_go;
  logic                        start;

  assign wr_go = !awready && !wready && !bvalid;
  assign start = wr_go && aw_q == fwsr_pkg::REG_CTRL && ws_q[0] && hstate == H_IDLE;

  // write channels taken in either order, answered once both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= fwsr_pkg::RESP_OKAY;
      aw_q <= '0;
      w_q <= '0;
      ws_q <= '0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_q <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_q <= wdata;
        ws_q <= wstrb;
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= aw_q == fwsr_pkg::REG_STAT ? fwsr_pkg::RESP_SLVERR : fwsr_pkg::RESP_OKAY;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // operand registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_addr <= '0;
      op_data <= '0;
    end else if (wr_go && aw_q == fwsr_pkg::REG_ADDR && ws_q[0]) begin
      op_addr <= w_q[fwsr_pkg::AW-1:0];
    end else if (wr_go && aw_q == fwsr_pkg::REG_DATA) begin
      if (ws_q[0]) begin
        op_data[7:0] <= w_q[7:0];
      end
      if (ws_q[1]) begin
        op_data[15:8] <= w_q[15:8];
      end
    end
  end

  // register reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= fwsr_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= fwsr_pkg::RESP_OKAY;
      unique case (araddr)
        fwsr_pkg::REG_ADDR: rdata <= 32'(op_addr);
        fwsr_pkg::REG_DATA: rdata <= 32'(op_data);
        fwsr_pkg::REG_CTRL: rdata <= 32'(op);
        fwsr_pkg::REG_STAT: rdata <= {rd_q, 13'h0, st_fail, st_ok, hstate != H_IDLE};
        default: begin
          rdata <= '0;
          rresp <= fwsr_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // command issue and toggle polling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hstate <= H_IDLE;
      op <= fwsr_pkg::CMD_READ;
      st_ok <= 1'b0;
      st_fail <= 1'b0;
      rd_q <= '0;
      first <= 1'b1;
      tog_first <= 1'b0;
      rechk <= 1'b0;
      link.req <= 1'b0;
      link.cmd <= fwsr_pkg::CMD_READ;
      link.addr <= '0;
      link.wdata <= '0;
    end else begin
      link.req <= 1'b0;
      unique case (hstate)
        H_IDLE: begin
          if (start) begin
            op <= w_q[2:0];
            st_ok <= 1'b0;
            st_fail <= 1'b0;
            hstate <= H_SEND;
          end
        end
        H_SEND: begin
          link.req <= 1'b1;
          link.cmd <= op;
          link.addr <= op_addr;
          link.wdata <= op_data;
          first <= 1'b1;
          rechk <= 1'b0;
          if (op == fwsr_pkg::CMD_READ) begin
            hstate <= H_WAIT;
          end else if (op == fwsr_pkg::CMD_PROG || op == fwsr_pkg::CMD_SECT_ERASE
                       || op == fwsr_pkg::CMD_CHIP_ERASE) begin
            hstate <= H_POLL;
          end else begin
            st_ok <= 1'b1;
            hstate <= H_IDLE;
          end
        end
        H_WAIT: begin
          if (link.rvalid) begin
            rd_q <= link.rdata;
            st_ok <= 1'b1;
            hstate <= H_IDLE;
          end
        end
        H_POLL: begin
          link.req <= 1'b1;
          link.cmd <= fwsr_pkg::CMD_READ;
          link.addr <= op_addr;
          hstate <= H_PWAIT;
        end
        H_PWAIT: begin
          if (link.rvalid) begin
            rd_q <= link.rdata;
            if (first) begin
              tog_first <= link.rdata[fwsr_pkg::TOGGLE_BIT];
              first <= 1'b0;
            end else if (link.rdata[fwsr_pkg::TOGGLE_BIT] == tog_first) begin
              st_ok <= 1'b1;
              hstate <= H_IDLE;
            end else if (link.rdata[fwsr_pkg::LIMIT_BIT] && rechk) begin
              hstate <= H_RESET;
            end else begin
              rechk <= link.rdata[fwsr_pkg::LIMIT_BIT];
              first <= 1'b1;
            end
            if (!(!first && link.rdata[fwsr_pkg::TOGGLE_BIT] == tog_first)
                && !(!first && link.rdata[fwsr_pkg::LIMIT_BIT] && rechk)) begin
              hstate <= H_POLL;
            end
          end
        end
        H_RESET: begin
          link.req <= 1'b1;
          link.cmd <= fwsr_pkg::CMD_RESET;
          st_fail <= 1'b1;
          hstate <= H_IDLE;
        end
        default: hstate <= H_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* verif/fwsr_link_asserts.sv */
// concurrent checks on the link between host controller and flash device
`timescale 1ns/1ps
`default_nettype none
module fwsr_link_asserts (
  input wire logic                    aclk,    // clock
  input wire logic                    aresetn, // sync reset, active low
  input wire logic                    req,     // request strobe
  input wire logic [2:0]              cmd,     // command code
  input wire logic [fwsr_pkg::AW-1:0] addr,    // word address
  input wire logic [fwsr_pkg::DW-1:0] wdata,   // program data
  input wire logic                    rvalid,  // read answer strobe
  input wire logic [fwsr_pkg::DW-1:0] rdata,   // read word
  input wire logic                    busy,    // device busy
  input wire logic                    failed   // failure pending reset
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic                    pm;  // last operation was a program
  logic                    fs;  // that program failed
  logic                    pb;  // written polling bit
  logic                    hit; // read pending to the busy program bank
  logic                    ph;  // earlier hitting answer seen
  logic                    pt;  // its toggle bit
  logic [fwsr_pkg::AW-1:0] pa;  // program address
  wire rd = req && cmd == fwsr_pkg::CMD_READ;
  wire bank = rd && pm && addr[5:4] == pa[5:4];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pm <= 1'b0;
      fs <= 1'b0;
    end else if (req && cmd == fwsr_pkg::CMD_PROG) begin
      pm <= 1'b1;
      fs <= 1'b0;
      pa <= addr;
      pb <= wdata[fwsr_pkg::POLL_BIT];
    end else begin
      if (req && (cmd == fwsr_pkg::CMD_SECT_ERASE || cmd == fwsr_pkg::CMD_CHIP_ERASE)) pm <= 1'b0;
      if (failed) fs <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hit <= 1'b0;
      ph <= 1'b0;
      pt <= 1'b0;
    end else begin
      hit <= bank && busy && !failed;
      if (!busy || failed) ph <= 1'b0;
      else if (rvalid && hit) begin
        ph <= 1'b1;
        pt <= rdata[fwsr_pkg::TOGGLE_BIT];
      end
    end
  end

  chk_read_answer: assert property (rd |=> rvalid) else $error("read not answered");
  chk_answer_cause: assert property (rvalid |-> $past(rd)) else $error("answer without read");
  chk_rdata_hold: assert property (!rd |=> $stable(rdata)) else $error("read word changed");
  chk_busy_prog: assert property (req && cmd == fwsr_pkg::CMD_PROG && !busy && !failed |=> ##1 busy [*8])
    else $error("program not busy");
  chk_poll_bit: assert property (rd && pm && addr == pa && busy && !failed ##1 busy && !failed
    |-> rdata[fwsr_pkg::POLL_BIT] == !pb) else $error("polling bit wrong");
  chk_limit_low: assert property (rvalid && hit && busy && !failed |-> !rdata[fwsr_pkg::LIMIT_BIT])
    else $error("limit flag set early");
  chk_toggle_flip: assert property (rvalid && hit && busy && !failed && ph
    |-> rdata[fwsr_pkg::TOGGLE_BIT] != pt) else $error("toggle bit stuck");
  chk_fail_limit: assert property (bank && failed ##1 failed |-> rdata[fwsr_pkg::LIMIT_BIT])
    else $error("limit flag missing");
  chk_done_array: assert property (rd && pm && !fs && addr == pa && !busy && !failed ##1 !busy
    |-> rdata[fwsr_pkg::POLL_BIT] == pb) else $error("array data missing");
endmodule
`default_nettype wire

/* verif/flash_write_status_reporting_tb.sv */
// bench: host and device over AXI4-Lite, plus a second device driven directly
`timescale 1ns/1ps
`default_nettype none
module flash_write_status_reporting_tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        arvalid = 1'b0;
  logic [3:0]  awaddr = 4'h0;
  logic [3:0]  araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        bready = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, busy, failed, busy_b, failed_b;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] mem [64];
  int          failures = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          seed = 32'h9818;
  fwsr_if link_a ();
  fwsr_if link_b ();

  fwsr_host i_fwsr_host (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .link(link_a.host));
  fwsr_device #(.WINDOW_CYCLES(20), .PULSE_LIMIT(8)) i_fwsr_device (.aclk(aclk), .aresetn(aresetn),
    .link(link_a.device), .busy(busy), .failed(failed));
  fwsr_device #(.WINDOW_CYCLES(20), .PULSE_LIMIT(8)) i_fwsr_device_b (.aclk(aclk), .aresetn(aresetn),
    .link(link_b.device), .busy(busy_b), .failed(failed_b));
  fwsr_link_asserts i_fwsr_link_asserts (.aclk(aclk), .aresetn(aresetn), .req(link_a.req),
    .cmd(link_a.cmd), .addr(link_a.addr), .wdata(link_a.wdata), .rvalid(link_a.rvalid),
    .rdata(link_a.rdata), .busy(busy), .failed(failed));

  always #5 aclk = ~aclk;

  task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      print_verdict();
    end
  end

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0, got}, {15'h0, exp});
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk_word({14'h0, bresp}, {14'h0, er});
    @(posedge aclk);
  endtask

  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // one host operation, then poll status until idle
  task automatic op(input logic [2:0] c, input logic [5:0] a, input logic [15:0] d, output logic [31:0] st);
    logic [1:0] r;
    axw(fwsr_pkg::REG_ADDR, {26'h0, a}, fwsr_pkg::RESP_OKAY);
    axw(fwsr_pkg::REG_DATA, {16'h0, d}, fwsr_pkg::RESP_OKAY);
    axw(fwsr_pkg::REG_CTRL, {29'h0, c}, fwsr_pkg::RESP_OKAY);
    do axr(fwsr_pkg::REG_STAT, st, r); while (st[fwsr_pkg::STAT_BUSY] !== 1'b0);
  endtask

  task automatic dcmd(input logic [2:0] c, input logic [5:0] a, input logic [15:0] d);
    link_b.req <= 1'b1;
    link_b.cmd <= c;
    link_b.addr <= a;
    link_b.wdata <= d;
    @(posedge aclk);
    link_b.req <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic dread(input logic [5:0] a, output logic [15:0] q);
    dcmd(fwsr_pkg::CMD_READ, a, 16'h0);
    q = link_b.rdata;
  endtask

  task automatic dwait();
    do @(posedge aclk); while (busy_b);
  endtask

  initial begin
    logic [31:0] st;
    logic [15:0] d, q0, q1;
    logic [5:0]  a;
    logic [1:0]  r;
    foreach (mem[k]) mem[k] = 16'hFFFF;
    link_b.req = 1'b0;
    link_b.cmd = 3'h0;
    link_b.addr = 6'h0;
    link_b.wdata = 16'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axr(fwsr_pkg::REG_STAT, st, r);
    chk_word(st[15:0], 16'h0);
    for (int i = 0; i < 6; i++) begin
      a = 6'($random(seed) & 31);
      d = 16'($random(seed)) & mem[a];
      mem[a] = d;
      op(fwsr_pkg::CMD_PROG, a, d, st);
      chk_word(st[15:0], 16'h2);
      op(fwsr_pkg::CMD_READ, a, 16'h0, st);
      chk_word(st[31:16], mem[a]);
    end
    op(fwsr_pkg::CMD_PROG, 6'd40, 16'h0000, st);
    op(fwsr_pkg::CMD_PROG, 6'd40, 16'h00FF, st);
    chk_word(st[15:0], 16'h4);
    op(fwsr_pkg::CMD_READ, 6'd40, 16'h0, st);
    chk_word(st[31:16], 16'h0000);
    op(fwsr_pkg::CMD_SECT_ERASE, 6'd0, 16'h0, st);
    op(fwsr_pkg::CMD_READ, 6'd5, 16'h0, st);
    chk_word(st[31:16], 16'hFFFF);
    op(fwsr_pkg::CMD_CHIP_ERASE, 6'd0, 16'h0, st);
    op(fwsr_pkg::CMD_READ, 6'd40, 16'h0, st);
    chk_word(st[31:16], 16'hFFFF);
    axw(fwsr_pkg::REG_STAT, 32'h0, fwsr_pkg::RESP_SLVERR);
    axw(4'h2, 32'h0, fwsr_pkg::RESP_OKAY);
    axr(4'h2, st, r);
    chk_word({14'h0, r}, {14'h0, fwsr_pkg::RESP_SLVERR});
    // only lane 0 strobed: upper byte of the operand keeps its zero
    wstrb <= 4'h1;
    axw(fwsr_pkg::REG_DATA, 32'h0000_A55A, fwsr_pkg::RESP_OKAY);
    wstrb <= 4'hF;
    axr(fwsr_pkg::REG_DATA, st, r);
    chk_word(st[15:0], 16'h005A);
    // directly driven device: status patterns
    dcmd(fwsr_pkg::CMD_PROG, 6'd16, 16'h0055);
    dread(6'd16, q0);
    dread(6'd16, q1);
    chk_bit(q0[7], 1'b1);
    chk_bit(q0[5], 1'b0);
    chk_bit(q1[6], ~q0[6]);
    dread(6'd0, q0);
    chk_word(q0, 16'hFFFF);
    dwait();
    dread(6'd16, q0);
    chk_word(q0, 16'h0055);
    dcmd(fwsr_pkg::CMD_PROG, 6'd48, 16'h1234);
    dwait();
    dcmd(fwsr_pkg::CMD_SECT_ERASE, 6'd48, 16'h0);
    dread(6'd48, q0);
    chk_bit(q0[3], 1'b0);
    repeat (10) @(posedge aclk);
    dcmd(fwsr_pkg::CMD_SECT_ERASE, 6'd56, 16'h0);
    repeat (12) @(posedge aclk);
    dread(6'd48, q0);
    chk_bit(q0[3], 1'b0);
    repeat (10) @(posedge aclk);
    dread(6'd56, q0);
    dread(6'd56, q1);
    chk_bit(q1[3], 1'b1);
    chk_bit(q1[7], 1'b0);
    chk_bit(q1[2], ~q0[2]);
    dcmd(fwsr_pkg::CMD_PROG, 6'd8, 16'h0000);
    dcmd(fwsr_pkg::CMD_SUSPEND, 6'd48, 16'h0);
    dread(6'd48, q0);
    dread(6'd48, q1);
    chk_bit(q1[6], q0[6]);
    chk_bit(q1[2], ~q0[2]);
    dread(6'd16, q0);
    chk_word(q0, 16'h0055);
    dcmd(fwsr_pkg::CMD_RESUME, 6'd48, 16'h0);
    dwait();
    dread(6'd8, q0);
    chk_word(q0, 16'hFFFF);
    dread(6'd56, q0);
    chk_word(q0, 16'hFFFF);
    dcmd(fwsr_pkg::CMD_CHIP_ERASE, 6'd0, 16'h0);
    dread(6'd16, q0);
    chk_bit(q0[3], 1'b1);
    dwait();
    dcmd(fwsr_pkg::CMD_PROG, 6'd16, 16'h0000);
    dwait();
    dcmd(fwsr_pkg::CMD_PROG, 6'd16, 16'h00FF);
    repeat (12) @(posedge aclk);
    dread(6'd16, q0);
    dread(6'd16, q1);
    chk_bit(q1[5], 1'b1);
    chk_bit(q1[6], ~q0[6]);
    chk_bit(failed_b, 1'b1);
    dcmd(fwsr_pkg::CMD_RESET, 6'd16, 16'h0);
    dread(6'd16, q0);
    chk_word(q0, 16'h0000);
    chk_bit(failed_b, 1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire
